// file: verilog/scan_settle_params.svh
`ifndef SCAN_SETTLE_PARAMS_SVH
`define SCAN_SETTLE_PARAMS_SVH
// Contract
// - delay code 0..7 selects 0,1,2,4,8,16,32,48 units of 128 clocks
// - in scan mode wait the switch delay after every channel change
// - in scan mode pull result_ready_n low for each finished result
// - a start by pin rise or command gives a settled first result
// - step settles in one cycle; fixed channel, average code 11 takes five
// - chop on halves the result rate in scan mode or at delay code 0; fixed channel with delay code above 0 drops it below half
// - loop bypass 0 routes the mux output straight to the converter
// - mux output pins stay driven whatever the bypass setting
// - bias sources current into positive input, sinks from negative input
// - bias reaches only the selected pair, never an unselected channel
// - averaging code 11,10,01,00 averages 1,4,16,64 first stage outputs
// - start pin rise begins converting; fall finishes current one, stops

`define OFF_CTRL        8'h00
`define OFF_SCAN_MASK   8'h04
`define OFF_CMD         8'h08
`define OFF_STATUS      8'h0c
`define OFF_INT_STAT    8'h10
`define OFF_INT_MASK    8'h14

`define CTRL_SCAN       0
`define CTRL_CHOP       1
`define CTRL_BYPASS     2
`define CTRL_BIAS_EN    3
`define CTRL_BIAS_HI    4
`define CTRL_DLY_LSB    5
`define CTRL_AVG_LSB    8
`define CTRL_PAIR_LSB   10
`define CTRL_WMASK      32'h0000_1fff

`define CMD_START       0
`define INT_RESULT      0
`define INT_STOP        1

`define CTRL_RESET      32'h0000_0304
`define SCAN_MASK_RESET 8'hff

`define SWITCH_UNIT_CYCLES 128
`define FILTER_UNIT_CYCLES 128
`define SETTLE_FILL_UNITS  5
`endif

// file: verilog/scan_settle_pkg.sv
package scan_settle_pkg;
   typedef enum logic [2:0] {
      ST_IDLE    = 3'h1,
      ST_SWITCH  = 3'h2,
      ST_CONVERT = 3'h4
   } seq_state_e;
endpackage : scan_settle_pkg

// file: verilog/switch_delay_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "scan_settle_params.svh"
module switch_delay_timer #(
   parameter int UNIT_CYCLES = `SWITCH_UNIT_CYCLES,
   parameter int CNT_W       = 13
) (
   input  wire logic             core_clk,
   input  wire logic             rst_b,
   input  wire logic             load,
   input  wire logic [2:0]       sel,
   output logic                  busy
);
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;

   function automatic logic [5:0] delay_units(input logic [2:0] s);
      case (s)
         3'h0: delay_units = 6'h00;
         3'h1: delay_units = 6'h01;
         3'h2: delay_units = 6'h02;
         3'h3: delay_units = 6'h04;
         3'h4: delay_units = 6'h08;
         3'h5: delay_units = 6'h10;
         3'h6: delay_units = 6'h20;
         default: delay_units = 6'h30;
      endcase
   endfunction : delay_units

   always_comb begin
      cnt_nxt = cnt_r;
      if (load) begin
         cnt_nxt = CNT_W'(delay_units(sel) * UNIT_CYCLES);
      end else if (cnt_r != '0) begin
         cnt_nxt = cnt_r - CNT_W'(1);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign busy = (cnt_r != '0);

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   longest_code_a: assert property (
      load && sel == 3'h7 |=> cnt_r == CNT_W'(48 * UNIT_CYCLES))
      else $error("delay code 7 did not load 48 units");
   code_three_a: assert property (
      load && sel == 3'h3 |=> cnt_r == CNT_W'(4 * UNIT_CYCLES))
      else $error("delay code 3 did not load 4 units");
   no_shorten_a: assert property (
      busy && !load && $changed(sel) |=> cnt_r == $past(cnt_r) - CNT_W'(1))
      else $error("delay changed while counting");
endmodule : switch_delay_timer
`default_nettype wire

// file: verilog/scan_settle_delay_and_bias_ctl.sv
`timescale 1ns/10ps
`default_nettype none
`include "scan_settle_params.svh"
module scan_settle_delay_and_bias_ctl #(
   parameter int SWITCH_UNIT_CYCLES = `SWITCH_UNIT_CYCLES,
   parameter int FILTER_UNIT_CYCLES = `FILTER_UNIT_CYCLES
) (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        start_pin,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [7:0]  s_axi_araddr,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             result_ready_n,
   output logic [2:0]       result_pair,
   output logic             adc_convert,
   output logic             chop_phase,
   output logic [3:0]       mux_pos_sel,
   output logic [3:0]       mux_neg_sel,
   output logic             mux_out_en,
   output logic             int_bypass_en,
   output logic [15:0]      bias_src_en,
   output logic [15:0]      bias_sink_en,
   output logic             bias_cur_hi,
   output logic             irq
);
   localparam int PW  = $clog2(FILTER_UNIT_CYCLES + 1);
   localparam int DCW = $clog2(48 * SWITCH_UNIT_CYCLES + 1);

   // register and bus state
   logic [31:0] ctrl_r, ctrl_nxt;
   logic [7:0]  scan_mask_r, scan_mask_nxt;
   logic [1:0]  int_stat_r, int_stat_nxt;
   logic [1:0]  int_mask_r, int_mask_nxt;
   logic        cmd_pend_r, cmd_pend_nxt;
   logic        aw_got_r, aw_got_nxt;
   logic        w_got_r, w_got_nxt;
   logic [7:0]  awaddr_q_r, awaddr_q_nxt;
   logic [31:0] wdata_q_r, wdata_q_nxt;
   logic [3:0]  wstrb_q_r, wstrb_q_nxt;
   logic        awready_r, awready_nxt;
   logic        wready_r, wready_nxt;
   logic        bvalid_r, bvalid_nxt;
   logic [1:0]  bresp_r, bresp_nxt;
   logic        arready_r, arready_nxt;
   logic        rvalid_r, rvalid_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [1:0]  rresp_r, rresp_nxt;
   logic        irq_r, irq_nxt;

   // sequencer state
   scan_settle_pkg::seq_state_e state_r, state_nxt;
   logic [2:0]  pair_r, pair_nxt;
   logic        phase_r, phase_nxt;
   logic        first_r, first_nxt;
   logic        single_r, single_nxt;
   logic        start_d_r;
   logic [6:0]  units_left_r, units_left_nxt;
   logic [PW-1:0] pre_r, pre_nxt;
   logic        rdy_n_r, rdy_n_nxt;
   logic [2:0]  res_pair_r, res_pair_nxt;
   logic        conv_r;
   logic [3:0]  pos_r, neg_r;
   logic        byp_r;
   logic [15:0] src_r, sink_r;
   logic        hi_r;
   logic        muxen_r;

   logic        dly_load;
   logic        dly_busy;
   logic        ev_result;
   logic        ev_stop;
   logic        start_take;
   logic [3:0]  pos_w, neg_w;
   logic [15:0] src_w, sink_w;
   logic [6:0]  avg_units;
   logic [6:0]  target_units;

   wire logic       scan_on = ctrl_r[`CTRL_SCAN];
   wire logic       chop_on = ctrl_r[`CTRL_CHOP];
   wire logic [1:0] avg_sel = ctrl_r[`CTRL_AVG_LSB +: 2];

   function automatic logic [31:0] strb_mask(input logic [3:0] s);
      strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction : strb_mask

   function automatic logic [2:0] next_pair(input logic [2:0] cur,
                                            input logic [7:0] m);
      logic [2:0] cand;
      logic       found;
      next_pair = cur;
      found = 1'h0;
      for (int k = 1; k <= 8; k++) begin
         cand = 3'(int'(cur) + k);
         if (!found && m[cand]) begin
            next_pair = cand;
            found = 1'h1;
         end
      end
   endfunction : next_pair

   switch_delay_timer #(
      .UNIT_CYCLES (SWITCH_UNIT_CYCLES),
      .CNT_W       (DCW)
   ) u_delay (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .load     (dly_load),
      .sel      (ctrl_r[`CTRL_DLY_LSB +: 3]),
      .busy     (dly_busy)
   );

   // averaging count: 11 -> 1, 10 -> 4, 01 -> 16, 00 -> 64
   assign avg_units = 7'(7'h01 << (2 * (3 - int'(avg_sel))));
   assign target_units = (!scan_on && avg_sel == 2'h3 && first_r) ?
                         7'(`SETTLE_FILL_UNITS) : avg_units;

   // chop phase swaps the pair polarity
   assign pos_w = {pair_nxt, phase_nxt};
   assign neg_w = {pair_nxt, ~phase_nxt};

   generate
      for (genvar i = 0; i < 16; i++) begin : g_bias
         assign src_w[i]  = ctrl_r[`CTRL_BIAS_EN] && pos_w == 4'(i);
         assign sink_w[i] = ctrl_r[`CTRL_BIAS_EN] && neg_w == 4'(i);
      end
   endgenerate

   // sequencer
   always_comb begin
      state_nxt = state_r;
      pair_nxt = pair_r;
      phase_nxt = phase_r;
      first_nxt = first_r;
      single_nxt = single_r;
      units_left_nxt = units_left_r;
      pre_nxt = pre_r;
      dly_load = 1'h0;
      ev_result = 1'h0;
      ev_stop = 1'h0;
      start_take = 1'h0;
      case (state_r)
         scan_settle_pkg::ST_IDLE: begin
            if ((start_pin && !start_d_r) || cmd_pend_r) begin
               start_take = 1'h1;
               single_nxt = !start_pin;
               first_nxt = 1'h1;
               phase_nxt = 1'h0;
               pair_nxt = (scan_on && scan_mask_r != 8'h00) ?
                          next_pair(3'h7, scan_mask_r) :
                          ctrl_r[`CTRL_PAIR_LSB +: 3];
               dly_load = scan_on || chop_on;
               state_nxt = scan_settle_pkg::ST_SWITCH;
            end
         end
         scan_settle_pkg::ST_SWITCH: begin
            if (!dly_busy) begin
               units_left_nxt = target_units;
               pre_nxt = PW'(FILTER_UNIT_CYCLES - 1);
               state_nxt = scan_settle_pkg::ST_CONVERT;
            end
         end
         scan_settle_pkg::ST_CONVERT: begin
            if (pre_r != '0) begin
               pre_nxt = pre_r - PW'(1);
            end else if (units_left_r != 7'h01) begin
               pre_nxt = PW'(FILTER_UNIT_CYCLES - 1);
               units_left_nxt = units_left_r - 7'h01;
            end else if (chop_on && !phase_r) begin
               phase_nxt = 1'h1;
               dly_load = 1'h1;
               state_nxt = scan_settle_pkg::ST_SWITCH;
            end else begin
               ev_result = 1'h1;
               phase_nxt = 1'h0;
               first_nxt = 1'h0;
               if (start_pin && !single_r) begin
                  if (scan_on && scan_mask_r != 8'h00) begin
                     pair_nxt = next_pair(pair_r, scan_mask_r);
                  end else begin
                     pair_nxt = ctrl_r[`CTRL_PAIR_LSB +: 3];
                  end
                  dly_load = scan_on || chop_on;
                  state_nxt = scan_settle_pkg::ST_SWITCH;
               end else begin
                  ev_stop = 1'h1;
                  state_nxt = scan_settle_pkg::ST_IDLE;
               end
            end
         end
         default: begin
            state_nxt = scan_settle_pkg::ST_IDLE;
         end
      endcase
      rdy_n_nxt = !ev_result;
      res_pair_nxt = ev_result ? pair_r : res_pair_r;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         state_r <= scan_settle_pkg::ST_IDLE;
         pair_r <= 3'h0;
         phase_r <= 1'h0;
         first_r <= 1'h0;
         single_r <= 1'h0;
         start_d_r <= 1'h0;
         units_left_r <= 7'h00;
         pre_r <= '0;
         rdy_n_r <= 1'h1;
         res_pair_r <= 3'h0;
         conv_r <= 1'h0;
         pos_r <= 4'h0;
         neg_r <= 4'h1;
         byp_r <= 1'h0;
         src_r <= 16'h0000;
         sink_r <= 16'h0000;
         hi_r <= 1'h0;
         muxen_r <= 1'h1;
      end else begin
         state_r <= state_nxt;
         pair_r <= pair_nxt;
         phase_r <= phase_nxt;
         first_r <= first_nxt;
         single_r <= single_nxt;
         start_d_r <= start_pin;
         units_left_r <= units_left_nxt;
         pre_r <= pre_nxt;
         rdy_n_r <= rdy_n_nxt;
         res_pair_r <= res_pair_nxt;
         conv_r <= (state_nxt == scan_settle_pkg::ST_CONVERT);
         pos_r <= pos_w;
         neg_r <= neg_w;
         byp_r <= !ctrl_r[`CTRL_BYPASS];
         src_r <= src_w;
         sink_r <= sink_w;
         hi_r <= ctrl_r[`CTRL_BIAS_HI];
         muxen_r <= 1'h1;
      end
   end

   // register file and bus slave
   always_comb begin
      ctrl_nxt = ctrl_r;
      scan_mask_nxt = scan_mask_r;
      int_mask_nxt = int_mask_r;
      int_stat_nxt = int_stat_r;
      cmd_pend_nxt = cmd_pend_r && !start_take;
      aw_got_nxt = aw_got_r;
      w_got_nxt = w_got_r;
      awaddr_q_nxt = awaddr_q_r;
      wdata_q_nxt = wdata_q_r;
      wstrb_q_nxt = wstrb_q_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (s_axi_awvalid && awready_r) begin
         aw_got_nxt = 1'h1;
         awaddr_q_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_r) begin
         w_got_nxt = 1'h1;
         wdata_q_nxt = s_axi_wdata;
         wstrb_q_nxt = s_axi_wstrb;
      end
      if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'h0;
      end
      if (aw_got_r && w_got_r && !bvalid_r) begin
         aw_got_nxt = 1'h0;
         w_got_nxt = 1'h0;
         bvalid_nxt = 1'h1;
         bresp_nxt = 2'h0;
         if (awaddr_q_r == `OFF_CTRL) begin
            ctrl_nxt = ((ctrl_r & ~strb_mask(wstrb_q_r)) |
                        (wdata_q_r & strb_mask(wstrb_q_r))) & `CTRL_WMASK;
         end else if (awaddr_q_r == `OFF_SCAN_MASK) begin
            if (wstrb_q_r[0]) scan_mask_nxt = wdata_q_r[7:0];
         end else if (awaddr_q_r == `OFF_CMD) begin
            if (wstrb_q_r[0] && wdata_q_r[`CMD_START]) cmd_pend_nxt = 1'h1;
         end else if (awaddr_q_r == `OFF_STATUS) begin
            bresp_nxt = 2'h0;
         end else if (awaddr_q_r == `OFF_INT_STAT) begin
            if (wstrb_q_r[0]) int_stat_nxt = int_stat_r & ~wdata_q_r[1:0];
         end else if (awaddr_q_r == `OFF_INT_MASK) begin
            if (wstrb_q_r[0]) int_mask_nxt = wdata_q_r[1:0];
         end else begin
            bresp_nxt = 2'h2;
         end
      end
      // hardware events win over a same-cycle clear
      if (ev_result) int_stat_nxt[`INT_RESULT] = 1'h1;
      if (ev_stop) int_stat_nxt[`INT_STOP] = 1'h1;
      if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'h0;
      end
      if (s_axi_arvalid && arready_r) begin
         rvalid_nxt = 1'h1;
         rresp_nxt = 2'h0;
         rdata_nxt = 32'h0000_0000;
         if (s_axi_araddr == `OFF_CTRL) begin
            rdata_nxt = ctrl_r;
         end else if (s_axi_araddr == `OFF_SCAN_MASK) begin
            rdata_nxt[7:0] = scan_mask_r;
         end else if (s_axi_araddr == `OFF_CMD) begin
            rdata_nxt[0] = cmd_pend_r;
         end else if (s_axi_araddr == `OFF_STATUS) begin
            rdata_nxt[11:0] = {cmd_pend_r, res_pair_r, pair_r, dly_busy,
                               phase_r, state_r};
         end else if (s_axi_araddr == `OFF_INT_STAT) begin
            rdata_nxt[1:0] = int_stat_r;
         end else if (s_axi_araddr == `OFF_INT_MASK) begin
            rdata_nxt[1:0] = int_mask_r;
         end else begin
            rresp_nxt = 2'h2;
         end
      end
      awready_nxt = !aw_got_nxt && !bvalid_nxt;
      wready_nxt = !w_got_nxt && !bvalid_nxt;
      arready_nxt = !rvalid_nxt;
      irq_nxt = |(int_stat_nxt & int_mask_nxt);
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         ctrl_r <= `CTRL_RESET;
         scan_mask_r <= `SCAN_MASK_RESET;
         int_stat_r <= 2'h0;
         int_mask_r <= 2'h0;
         cmd_pend_r <= 1'h0;
         aw_got_r <= 1'h0;
         w_got_r <= 1'h0;
         awaddr_q_r <= 8'h00;
         wdata_q_r <= 32'h0000_0000;
         wstrb_q_r <= 4'h0;
         awready_r <= 1'h1;
         wready_r <= 1'h1;
         bvalid_r <= 1'h0;
         bresp_r <= 2'h0;
         arready_r <= 1'h1;
         rvalid_r <= 1'h0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= 2'h0;
         irq_r <= 1'h0;
      end else begin
         ctrl_r <= ctrl_nxt;
         scan_mask_r <= scan_mask_nxt;
         int_stat_r <= int_stat_nxt;
         int_mask_r <= int_mask_nxt;
         cmd_pend_r <= cmd_pend_nxt;
         aw_got_r <= aw_got_nxt;
         w_got_r <= w_got_nxt;
         awaddr_q_r <= awaddr_q_nxt;
         wdata_q_r <= wdata_q_nxt;
         wstrb_q_r <= wstrb_q_nxt;
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         arready_r <= arready_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
         irq_r <= irq_nxt;
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign result_ready_n = rdy_n_r;
   assign result_pair = res_pair_r;
   assign adc_convert = conv_r;
   assign chop_phase = phase_r;
   assign mux_pos_sel = pos_r;
   assign mux_neg_sel = neg_r;
   assign mux_out_en = muxen_r;
   assign int_bypass_en = byp_r;
   assign bias_src_en = src_r;
   assign bias_sink_en = sink_r;
   assign bias_cur_hi = hi_r;
   assign irq = irq_r;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   delay_hold_a: assert property (
      state_r == scan_settle_pkg::ST_SWITCH && dly_busy |=>
      state_r == scan_settle_pkg::ST_SWITCH && !adc_convert)
      else $error("conversion began during switch delay");
   result_low_a: assert property (
      ev_result |=> !result_ready_n ##1 result_ready_n)
      else $error("result ready not pulsed low");
   start_go_a: assert property (
      state_r == scan_settle_pkg::ST_IDLE && start_pin && !start_d_r |=>
      state_r == scan_settle_pkg::ST_SWITCH)
      else $error("start pin rise not taken");
   fill_five_a: assert property (
      $rose(state_r == scan_settle_pkg::ST_CONVERT) && $past(first_r) &&
      !$past(scan_on) && $past(avg_sel) == 2'h3 |-> units_left_r == 7'h05)
      else $error("first fixed result not five units");
   chop_pair_a: assert property (
      ev_result && chop_on |-> chop_phase && mux_pos_sel[0] &&
      !mux_neg_sel[0])
      else $error("chopped result after one phase");
   bypass_route_a: assert property (
      $fell(ctrl_r[`CTRL_BYPASS]) |=> int_bypass_en)
      else $error("internal bypass not selected");
   mux_active_a: assert property (mux_out_en)
      else $error("mux output disabled");
   bias_pair_a: assert property (
      bias_src_en != 16'h0000 |-> $onehot(bias_src_en) &&
      bias_src_en[mux_pos_sel] && bias_sink_en[mux_neg_sel])
      else $error("bias not on selected pair");
   avg_count_a: assert property (
      $rose(state_r == scan_settle_pkg::ST_CONVERT) && $past(scan_on) &&
      $past(avg_sel) == 2'h0 |-> units_left_r == 7'h40)
      else $error("average 64 not loaded");
   stop_after_a: assert property (
      ev_result && !start_pin |=> state_r == scan_settle_pkg::ST_IDLE)
      else $error("did not stop after start fell");

   scan_result_c: cover property (ev_result && scan_on ##[1:40] ev_result);
   chop_result_c: cover property (ev_result && chop_on);
   delayed_switch_c: cover property (dly_busy ##1 !dly_busy);
   stop_irq_c: cover property (ev_stop ##1 irq);
endmodule : scan_settle_delay_and_bias_ctl
`default_nettype wire

// file: dv/host_start.sv
`timescale 1ns/10ps
`default_nettype none
// host side: holds start_pin as asked, spacing set by the bench
module host_start (
   input  wire logic core_clk,
   input  wire logic run,
   output logic      start_pin
);
   always_ff @(posedge core_clk) begin
      start_pin <= run;
   end
endmodule : host_start
`default_nettype wire

// file: dv/scan_settle_delay_and_bias_ctl_bench.sv
`timescale 1ns/10ps
`default_nettype none
module scan_settle_delay_and_bias_ctl_bench;
   logic core_clk = 0, rst_b = 0, run = 0, start_pin;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf, mux_pos_sel, mux_neg_sel;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, result_ready_n, adc_convert, chop_phase;
   logic mux_out_en, int_bypass_en, bias_cur_hi, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [2:0] result_pair;
   logic [15:0] bias_src_en, bias_sink_en;
   logic [33:0] q[$];
   int fails = 0, checks_done = 0, cyc = 0, p[8], p1, p2;
   int u[8] = '{0, 1, 2, 4, 8, 16, 32, 48};
   logic [7:0] r;
   always #50 core_clk = ~core_clk;
   always @(posedge core_clk) cyc <= cyc + 1;
   host_start u_host_start (.core_clk, .run, .start_pin);
   scan_settle_delay_and_bias_ctl #(
      .SWITCH_UNIT_CYCLES(4), .FILTER_UNIT_CYCLES(4)
   ) u_scan_settle_delay_and_bias_ctl (
      .core_clk, .rst_b, .start_pin, .s_axi_awvalid, .s_axi_awready,
      .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
      .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
      .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .result_ready_n,
      .result_pair, .adc_convert, .chop_phase, .mux_pos_sel,
      .mux_neg_sel, .mux_out_en, .int_bypass_en, .bias_src_en,
      .bias_sink_en, .bias_cur_hi, .irq);
   task automatic chk(input logic [33:0] g, input logic [33:0] e);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("ERROR %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : test_done
   // read data checked by the monitor against the oldest note
   always @(posedge core_clk) begin
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
         chk({s_axi_rresp, s_axi_rdata}, q.pop_front());
      end
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_bready <= 1;
      do begin
         @(posedge core_clk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      q.push_back(e);
      @(posedge core_clk);
      s_axi_arvalid <= 1;
      s_axi_araddr <= a;
      s_axi_rready <= 1;
      do @(posedge core_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 0;
      do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 0;
   endtask : rd
   task automatic pulse;
      int n;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (result_ready_n !== 1'b0 && n < 5000);
      if (n >= 5000) chk(0, 1);
   endtask : pulse
   task automatic meas(output int pd);
      int t0;
      pulse();
      t0 = cyc;
      pulse();
      pd = cyc - t0;
   endtask : meas
   initial begin
      repeat (60000) @(posedge core_clk);
      fails++;
      test_done();
   end
   initial begin
      void'($urandom(22));
      repeat (4) @(posedge core_clk);
      rst_b <= 1;
      chk(mux_out_en, 1);
      rd(8'h00, {2'h0, 32'h0000_0304});
      r = 8'($urandom);
      wr(8'h04, {24'h0, r});
      rd(8'h04, {2'h0, 24'h0, r});
      rd(8'h20, {2'h2, 32'h0});
      $display("registers done");
      wr(8'h04, 32'h0000_0003);
      run <= 1;
      for (int d = 0; d < 8; d++) begin
         wr(8'h00, 32'h0000_0305 | (d << 5));
         pulse();
         pulse();
         meas(p[d]);
         chk(p[d] - p[0], u[d] * 4);
      end
      wr(8'h00, 32'h0000_0005);
      pulse();
      meas(p1);
      chk(p1 - p[0], 63 * 4);
      $display("switch delay done");
      wr(8'h00, 32'h0000_0200);
      @(posedge core_clk);
      chk(int_bypass_en, 1);
      chk(mux_out_en, 1);
      pulse();
      meas(p1);
      wr(8'h00, 32'h0000_0202);
      pulse();
      pulse();
      meas(p2);
      chk(p2, 2 * p1);
      $display("chop done");
      wr(8'h00, 32'h0000_0e18);
      pulse();
      pulse();
      chk(mux_pos_sel, 6);
      chk(bias_src_en, 16'h0040);
      chk(bias_sink_en, 16'h0080);
      chk(bias_cur_hi, 1);
      $display("bias done");
      wr(8'h14, 32'h0000_0001);
      pulse();
      repeat (3) @(posedge core_clk);
      chk(irq, 1);
      run <= 0;
      repeat (400) @(posedge core_clk);
      wr(8'h10, 32'h0000_0003);
      repeat (3) @(posedge core_clk);
      chk(irq, 0);
      rd(8'h10, {2'h0, 32'h0});
      wr(8'h08, 32'h0000_0001);
      pulse();
      chk(result_pair, 3);
      $display("interrupt and command done");
      test_done();
   end
endmodule : scan_settle_delay_and_bias_ctl_bench
`default_nettype wire
